// ---- core/uart_core.sv ----
// uart transceiver with apb register slave, framing, parity and clock source selection
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

// Contract
// R1 - parity generated and checked only in seven and eight bit formats when enabled
// R2 - parity select: 00 odd, 01 even, 10 mark, 11 space
// R3 - char length bits: 00 eight, 01 seven, 10 nine data bits
// R4 - both length bits set: internal loopback with nine bit frames
// R5 - error flags read only, cleared by status read; global error follows them
// R6 - buffer full sets on received character, clears on buffer read
// R7 - tx empty is one at reset, sets on transfer, clears on buffer write
// R8 - nine bit format sends and latches ninth bit, eight buffer bits data
// R9 - no parity in nine bit format; shared bit is the ninth bit
// R10 - attention bit writable, cleared by a received character with ninth bit set
// R11 - transmitting bit high during frames, drops after last stop bit
// R12 - receiving bit set on framing error, cleared when line returns high
// R13 - one stop bit, or two when the stop count bit is set
// R14 - short stop option makes the last stop bit seven eighths long
// R15 - receiver needs only one stop bit
// R16 - transmit pin driven only while transmit pin select is set
// R17 - async uses sixteen ticks per bit, sync one clock per bit
// R18 - rx and tx each pick internal baud generator or external clock pin
// R19 - rx and tx interrupt enables gate requests, both zero after reset
// R20 - external clock pin as output carries the internal baud clock
// R21 - start low, resample at half bit, then sample each bit mid-bit
// R22 - sync mode: transmit on rising, receive on falling clock edge
// R23 - tx request pending while tx empty and tx enable set
// R24 - rx request pending while buffer full and rx enable set
// R25 - character completing with buffer still full sets overrun
// R26 - low line at first stop sample sets framing error
module uart_core
    import uart_pkg::*;
#(
    parameter logic [11:0] BAUD_DIV_RESET = BAUD_DIV_DEFAULT
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serialInPin,
    output logic             serialOutPin,
    output logic             serialOutPinOe,
    input  wire logic        extClockPinIn,
    output logic             extClockPinOut,
    output logic             extClockPinOe,
    output logic             rxIrq,
    output logic             txIrq
);

    localparam uart_state_type STATE_RESET = '{
        rxSync: 3'h7, rxLvl: 1'b1, baudDiv: BAUD_DIV_RESET, ctrl: CTRL_RESET, intClk: INTCLK_RESET,
        txBufferEmpty: 1'b1, txState: TX_IDLE, txLine: 1'b1, rxState: RX_IDLE, default: '0};

    uart_state_type st_q;
    uart_state_type st_d;

    logic       nineBit;
    logic       sevenBit;
    logic       loopBack;
    logic [3:0] lastBit;
    logic       parityOn;
    logic       syncMode;
    logic       intTick;
    logic       ckxRise;
    logic       ckxFall;
    logic       txTick;
    logic       rxTick;
    logic [4:0] bitTicks;
    logic       txLastStop;
    logic [4:0] txTicks;
    logic       txBitEnd;
    logic       rxIn;
    logic       rxSample;
    logic [7:0] dataMask;
    logic       setupPhase;
    logic       accessPhase;
    logic [9:0] regIdx;
    logic       regHit;
    logic       rxDoneEvt;

    function automatic logic parity_bit(input logic [7:0] d, input logic hi, input logic lo);
        unique case ({hi, lo})
            2'b00:   parity_bit = ~^d;
            2'b01:   parity_bit = ^d;
            2'b10:   parity_bit = 1'b1;
            2'b11:   parity_bit = 1'b0;
        endcase
    endfunction

    assign nineBit    = st_q.ctrl[CHAR_LEN_HI_BIT];
    assign sevenBit   = !nineBit && st_q.ctrl[CHAR_LEN_LO_BIT];
    assign loopBack   = nineBit && st_q.ctrl[CHAR_LEN_LO_BIT];
    assign lastBit    = nineBit ? 4'h8 : (sevenBit ? 4'h6 : 4'h7);                // [R3]
    assign parityOn   = st_q.ctrl[PARITY_ENABLE_BIT] && !nineBit;                  // [R1] [R9]
    assign syncMode   = st_q.intClk[MODE_SEL_BIT];
    assign intTick    = (st_q.baudCnt == 12'h000);
    assign ckxRise    = (st_q.ckxSync[1] == st_q.ckxSync[2]) && st_q.ckxSync[2] && !st_q.ckxLvl;
    assign ckxFall    = (st_q.ckxSync[1] == st_q.ckxSync[2]) && !st_q.ckxSync[2] && st_q.ckxLvl;
    // sync mode: tx moves on the rising clock edge, rx samples on the falling one
    assign txTick     = st_q.intClk[TX_EXT_CLK_BIT] ? ckxRise
                        : (intTick && !(syncMode && st_q.baudClk));               // [R18] [R22]
    assign rxTick     = st_q.intClk[RX_EXT_CLK_BIT] ? (syncMode ? ckxFall : ckxRise)
                        : (intTick && !(syncMode && !st_q.baudClk));              // [R18] [R22]
    assign bitTicks   = syncMode ? 5'h01 : TICKS_PER_BIT;                          // [R17]
    assign txLastStop = (st_q.txState == TX_STOP2)
                        || (st_q.txState == TX_STOP1 && !st_q.intClk[TWO_STOP_BIT]);
    assign txTicks    = (!syncMode && st_q.intClk[SHORT_STOP_BIT] && txLastStop)
                        ? SHORT_STOP_TICKS : bitTicks;                             // [R14]
    assign txBitEnd   = txTick && (st_q.txCnt == txTicks - 5'h01);
    assign rxIn       = loopBack ? st_q.txLine : st_q.rxLvl;                       // [R4]
    assign rxSample   = rxTick && (st_q.rxCnt == bitTicks - 5'h01);
    assign dataMask   = sevenBit ? 8'h7f : 8'hff;
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign regIdx      = paddr[11:2];
    assign regHit      = (regIdx >= CTRL_IDX) && (regIdx <= BAUD_IDX) && (paddr[1:0] == 2'b00);
    assign rxDoneEvt   = (st_q.rxState == RX_STOP) && rxSample;

    always_comb begin
        logic txLoad;
        logic txFinish;
        txLoad   = 1'b0;
        txFinish = 1'b0;
        st_d     = st_q;

        // three-stage input synchronisers, a change counts once stages two and three agree
        st_d.rxSync  = {st_q.rxSync[1:0], serialInPin};
        st_d.ckxSync = {st_q.ckxSync[1:0], extClockPinIn};
        if (st_q.rxSync[1] == st_q.rxSync[2]) begin
            st_d.rxLvl = st_q.rxSync[2];
        end
        if (st_q.ckxSync[1] == st_q.ckxSync[2]) begin
            st_d.ckxLvl = st_q.ckxSync[2];
        end

        // internal baud generator; its square wave can drive the clock pin
        if (intTick) begin
            st_d.baudCnt = st_q.baudDiv;
            st_d.baudClk = !st_q.baudClk;
        end else begin
            st_d.baudCnt = st_q.baudCnt - 12'h001;
        end

        // register reads: data and the flags that a read clears are taken in the setup phase
        if (setupPhase && !pwrite) begin
            st_d.rdRbfl = 1'b0;
            st_d.rdErr  = 3'h0;
            case (regIdx)
                CTRL_IDX:   st_d.prdata = {24'h0, st_q.ctrl[7:3],
                                st_q.overrunError || st_q.framingError || st_q.parityError,
                                st_q.rxBufferFull, st_q.txBufferEmpty};                        // [R5]
                RXSTAT_IDX: begin
                    st_d.prdata = {24'h0, st_q.overrunError, st_q.framingError, st_q.parityError,
                                   st_q.spare, st_q.rxNinthBit, st_q.attentionMode,
                                   st_q.transmittingFlag, st_q.receivingFlag};
                    st_d.rdErr  = {st_q.overrunError, st_q.framingError, st_q.parityError};
                end
                INTCLK_IDX: st_d.prdata = {24'h0, st_q.intClk};
                TXBUF_IDX:  st_d.prdata = {24'h0, st_q.txHold};
                RXBUF_IDX:  begin
                    st_d.prdata = {24'h0, st_q.rxHold};
                    st_d.rdRbfl = st_q.rxBufferFull;
                end
                BAUD_IDX:   st_d.prdata = {15'h0, st_q.ckxDrive, 4'h0, st_q.baudDiv};
                default:    st_d.prdata = 32'h0;
            endcase
        end

        // read side effects only clear what the read actually returned, so a new event survives
        if (accessPhase && !pwrite) begin
            if (regIdx == RXBUF_IDX && st_q.rdRbfl) begin
                st_d.rxBufferFull = 1'b0;                                                      // [R6]
            end
            if (regIdx == RXSTAT_IDX) begin
                st_d.overrunError = st_q.overrunError && !st_q.rdErr[2];                       // [R5]
                st_d.framingError = st_q.framingError && !st_q.rdErr[1];                       // [R5]
                st_d.parityError  = st_q.parityError && !st_q.rdErr[0];                        // [R5]
            end
        end

        if (accessPhase && pwrite) begin
            case (regIdx)
                CTRL_IDX:   st_d.ctrl = pwdata[7:0] & CTRL_WR_MASK;
                RXSTAT_IDX: begin
                    st_d.spare         = pwdata[SPARE_BIT];
                    st_d.attentionMode = pwdata[ATTENTION_BIT];                                // [R10]
                end
                INTCLK_IDX: st_d.intClk = pwdata[7:0];
                TXBUF_IDX:  begin
                    st_d.txHold        = pwdata[7:0];
                    st_d.txBufferEmpty = 1'b0;                                                 // [R7]
                end
                BAUD_IDX:   begin
                    st_d.baudDiv  = pwdata[11:0];
                    st_d.ckxDrive = pwdata[EXT_CLK_DRIVE_BIT];
                end
                default:    ;
            endcase
        end

        // transmitter
        if (txTick && st_q.txState != TX_IDLE) begin
            st_d.txCnt = txBitEnd ? 5'h00 : st_q.txCnt + 5'h01;
        end
        unique case (st_q.txState)
            TX_IDLE:   txLoad = !st_d.txBufferEmpty && (txTick || !syncMode);                 // [R22]
            TX_START:  if (txBitEnd) begin
                st_d.txState = TX_DATA;
            end
            TX_DATA:   if (txBitEnd) begin
                if (st_q.txBit == lastBit) begin
                    st_d.txState = parityOn ? TX_PARITY : TX_STOP1;                            // [R1] [R9]
                end else begin
                    st_d.txBit = st_q.txBit + 4'h1;
                end
            end
            TX_PARITY: if (txBitEnd) begin
                st_d.txState = TX_STOP1;
            end
            TX_STOP1:  if (txBitEnd) begin
                if (st_q.intClk[TWO_STOP_BIT]) begin
                    st_d.txState = TX_STOP2;                                                   // [R13]
                end else begin
                    txFinish = 1'b1;
                end
            end
            TX_STOP2:  if (txBitEnd) begin
                txFinish = 1'b1;
            end
        endcase
        if (txFinish) begin
            if (!st_d.txBufferEmpty) begin
                txLoad = 1'b1;
            end else begin
                st_d.txState          = TX_IDLE;
                st_d.transmittingFlag = 1'b0;                                                  // [R11]
            end
        end
        if (txLoad) begin
            st_d.txShift          = {st_q.ctrl[PARITY_SEL_LO_BIT], st_d.txHold};              // [R8]
            st_d.txBufferEmpty    = 1'b1;                                                      // [R7]
            st_d.transmittingFlag = 1'b1;                                                      // [R11]
            st_d.txState          = TX_START;
            st_d.txCnt            = 5'h00;
            st_d.txBit            = 4'h0;
        end
        unique case (st_d.txState)
            TX_START:  st_d.txLine = 1'b0;
            TX_DATA:   st_d.txLine = st_d.txShift[st_d.txBit];
            TX_PARITY: st_d.txLine = parity_bit(st_d.txShift[7:0] & dataMask,
                           st_q.ctrl[PARITY_SEL_HI_BIT], st_q.ctrl[PARITY_SEL_LO_BIT]);       // [R2]
            default:   st_d.txLine = 1'b1;
        endcase

        // receiver
        if (rxTick && st_q.rxState inside {RX_DATA, RX_PARITY, RX_STOP}) begin
            st_d.rxCnt = rxSample ? 5'h00 : st_q.rxCnt + 5'h01;
        end
        unique case (st_q.rxState)
            RX_IDLE:   if (rxTick && !rxIn) begin
                st_d.rxCnt       = 5'h00;
                st_d.rxBit       = 4'h0;
                st_d.rxParityBad = 1'b0;
                st_d.rxState     = syncMode ? RX_DATA : RX_START;                             // [R21]
            end
            RX_START:  if (rxTick) begin
                if (st_q.rxCnt == HALF_BIT_TICKS - 5'h01) begin
                    st_d.rxCnt   = 5'h00;
                    st_d.rxState = rxIn ? RX_IDLE : RX_DATA;                                   // [R21]
                end else begin
                    st_d.rxCnt = st_q.rxCnt + 5'h01;
                end
            end
            RX_DATA:   if (rxSample) begin
                st_d.rxShift[st_q.rxBit] = rxIn;                                               // [R21]
                if (st_q.rxBit == lastBit) begin
                    st_d.rxState = parityOn ? RX_PARITY : RX_STOP;
                end else begin
                    st_d.rxBit = st_q.rxBit + 4'h1;
                end
            end
            RX_PARITY: if (rxSample) begin
                st_d.rxParityBad = rxIn != parity_bit(st_q.rxShift[7:0] & dataMask,
                                   st_q.ctrl[PARITY_SEL_HI_BIT], st_q.ctrl[PARITY_SEL_LO_BIT]);
                st_d.rxState     = RX_STOP;
            end
            RX_STOP:   if (rxSample) begin
                // only one stop bit is checked, whatever the transmit setting
                st_d.rxState = rxIn ? RX_IDLE : RX_BREAK;                                      // [R15]
                if (!rxIn) begin
                    st_d.framingError  = 1'b1;                                                 // [R26]
                    st_d.receivingFlag = 1'b1;                                                 // [R12]
                end
            end
            RX_BREAK:  if (rxIn) begin
                st_d.receivingFlag = 1'b0;                                                     // [R12]
                st_d.rxState       = RX_IDLE;
            end
        endcase
        if (rxDoneEvt) begin
            // on overrun the earlier character is kept
            if (st_d.rxBufferFull) begin
                st_d.overrunError = 1'b1;                                                      // [R25]
            end else begin
                st_d.rxHold       = st_q.rxShift[7:0] & dataMask;
                st_d.rxNinthBit   = nineBit && st_q.rxShift[8];                                // [R8]
                st_d.rxBufferFull = 1'b1;                                                      // [R6]
            end
            if (parityOn && st_q.rxParityBad) begin
                st_d.parityError = 1'b1;                                                       // [R1]
            end
            if (nineBit && st_q.rxShift[8]) begin
                st_d.attentionMode = 1'b0;                                                     // [R10]
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata         = st_q.prdata;
    assign pready         = 1'b1;
    assign pslverr        = accessPhase && !regHit;
    assign serialOutPin   = st_q.txLine;
    assign serialOutPinOe = st_q.intClk[TX_PIN_SEL_BIT];                       // [R16]
    assign extClockPinOut = st_q.baudClk;                                      // [R20]
    assign extClockPinOe  = st_q.ckxDrive;                                     // [R20]
    assign rxIrq          = st_q.rxBufferFull && st_q.intClk[RX_IRQ_EN_BIT];   // [R24] [R19]
    assign txIrq          = st_q.txBufferEmpty && st_q.intClk[TX_IRQ_EN_BIT];  // [R23] [R19]

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    tx_holding_buffer_write_clears_a: assert property ( // [R7]
        accessPhase && pwrite && regIdx == TXBUF_IDX
        |=> !st_q.txBufferEmpty || st_q.txState == TX_START)
        else $error("tx empty flag not cleared by buffer write");

    rx_done_full_a: assert property ( // [R6]
        rxDoneEvt |=> st_q.rxBufferFull)
        else $error("buffer full flag not set after character");

    overrun_flag_a: assert property ( // [R25]
        rxDoneEvt && st_q.rxBufferFull && !(accessPhase && regIdx == RXBUF_IDX)
        |=> st_q.overrunError && $stable(st_q.rxHold))
        else $error("overrun not flagged or buffer overwritten");

    framing_error_a: assert property ( // [R26] [R12]
        rxDoneEvt && !rxIn |=> st_q.framingError && st_q.receivingFlag && st_q.rxState == RX_BREAK)
        else $error("framing error not flagged");

    attention_clear_a: assert property ( // [R10]
        rxDoneEvt && nineBit && st_q.rxShift[8] |=> !st_q.attentionMode)
        else $error("attention mode not cleared by ninth bit");

    tx_busy_flag_a: assert property ( // [R11]
        st_q.txState != TX_IDLE |-> st_q.transmittingFlag)
        else $error("transmitting flag low during frame");

    nine_no_parity_a: assert property ( // [R9]
        nineBit && st_q.txState == TX_DATA && txBitEnd && st_q.txBit == 4'h8 |=> st_q.txState == TX_STOP1)
        else $error("parity sent in nine bit format");

    seven_parity_a: assert property ( // [R1]
        sevenBit && parityOn && st_q.txState == TX_DATA && txBitEnd && st_q.txBit == 4'h6
        |=> st_q.txState == TX_PARITY ##0 st_q.txLine == parity_bit(st_q.txShift[7:0] & 8'h7f,
            st_q.ctrl[PARITY_SEL_HI_BIT], st_q.ctrl[PARITY_SEL_LO_BIT]))
        else $error("seven bit parity frame wrong");

    status_read_clears_a: assert property ( // [R5]
        accessPhase && !pwrite && regIdx == RXSTAT_IDX && st_q.rdErr[1] && !(rxDoneEvt && !rxIn)
        |=> !st_q.framingError)
        else $error("framing flag not cleared by status read");

    rx_irq_drop_a: assert property ( // [R24]
        accessPhase && !pwrite && regIdx == RXBUF_IDX && st_q.rdRbfl && !rxDoneEvt |=> !rxIrq)
        else $error("rx request still pending after buffer read");

endmodule

// ---- core/uart_pkg.sv ----
// package: register map, field positions, reset values, timing counts and state types of the uart
package uart_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [9:0] CTRL_IDX   = 10'h0ba;
    localparam logic [9:0] RXSTAT_IDX = 10'h0bb;
    localparam logic [9:0] INTCLK_IDX = 10'h0bc;
    localparam logic [9:0] TXBUF_IDX  = 10'h0bd;
    localparam logic [9:0] RXBUF_IDX  = 10'h0be;
    localparam logic [9:0] BAUD_IDX   = 10'h0bf;

    // control and status register fields
    localparam int PARITY_ENABLE_BIT = 7;
    localparam int PARITY_SEL_HI_BIT = 6;
    localparam int PARITY_SEL_LO_BIT = 5;
    localparam int CHAR_LEN_HI_BIT   = 4;
    localparam int CHAR_LEN_LO_BIT   = 3;
    localparam logic [7:0] CTRL_WR_MASK = 8'hf8;

    // receive status register writable fields
    localparam int SPARE_BIT     = 4;
    localparam int ATTENTION_BIT = 2;

    // interrupt and clock select register fields
    localparam int TWO_STOP_BIT   = 7;
    localparam int SHORT_STOP_BIT = 6;
    localparam int TX_PIN_SEL_BIT = 5;
    localparam int MODE_SEL_BIT   = 4;
    localparam int RX_EXT_CLK_BIT = 3;
    localparam int TX_EXT_CLK_BIT = 2;
    localparam int RX_IRQ_EN_BIT  = 1;
    localparam int TX_IRQ_EN_BIT  = 0;

    // baud register fields
    localparam int EXT_CLK_DRIVE_BIT = 16;

    // reset values
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [7:0]  INTCLK_RESET     = 8'h00;
    localparam logic [11:0] BAUD_DIV_DEFAULT = 12'h001;

    // sixteen ticks per bit in async mode; short stop is 7/8 of that
    localparam logic [4:0] TICKS_PER_BIT    = 5'h10;
    localparam logic [4:0] HALF_BIT_TICKS   = 5'h08;
    localparam logic [4:0] SHORT_STOP_TICKS = 5'h0e;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK} rx_state_type;

    typedef struct packed {
        logic [2:0]   rxSync;
        logic         rxLvl;
        logic [2:0]   ckxSync;
        logic         ckxLvl;
        logic [11:0]  baudCnt;
        logic         baudClk;
        logic [11:0]  baudDiv;
        logic         ckxDrive;
        logic [7:0]   ctrl;
        logic [7:0]   intClk;
        logic         rxBufferFull;
        logic         txBufferEmpty;
        logic         overrunError;
        logic         framingError;
        logic         parityError;
        logic         spare;
        logic         rxNinthBit;
        logic         attentionMode;
        logic         transmittingFlag;
        logic         receivingFlag;
        tx_state_type txState;
        logic [4:0]   txCnt;
        logic [3:0]   txBit;
        logic [8:0]   txShift;
        logic         txLine;
        logic [7:0]   txHold;
        rx_state_type rxState;
        logic [4:0]   rxCnt;
        logic [3:0]   rxBit;
        logic [8:0]   rxShift;
        logic         rxParityBad;
        logic [7:0]   rxHold;
        logic [31:0]  prdata;
        logic         rdRbfl;
        logic [2:0]   rdErr;
    } uart_state_type;

endpackage

// ---- bench/line_partner.sv ----
// remote serial line model: async frames at sixteen clocks per bit, lsb first
`timescale 1ns/1ps
module line_partner #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic mclk,
    input  wire logic lineIn,
    output logic      lineOut
);
    initial lineOut = 1'b1;
    // bit 0 of a frame is its start bit; the line idles high afterwards
    task automatic send(input logic [9:0] bits);
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            lineOut <= bits[i];
            repeat (BIT_CLKS - 1) @(posedge mclk);
        end
        @(posedge mclk);
        lineOut <= 1'b1;
    endtask
    task automatic recv(output logic [9:0] bits);
        int n;
        n = 0;
        while (lineIn !== 1'b0 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        repeat (BIT_CLKS / 2) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            bits[i] = lineIn;
            repeat (BIT_CLKS) @(posedge mclk);
        end
    endtask
endmodule

// ---- bench/uart_control_status_framing_bench.sv ----
// register and serial line tests of the uart core
`timescale 1ns/1ps
module uart_control_status_framing_bench;
    import uart_pkg::*;
    logic        mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, serialInPin, serialOutPin, serialOutPinOe, extClockPinOut, extClockPinOe;
    logic        rxIrq, txIrq, txLine, slvErr, ext_clock_pin = 1'b0;
    logic [9:0]  bits;
    int          fails = 0, checks = 0, cyc = 0;
    always #2 mclk = ~mclk;
    // free-running link clock on the external clock pin
    always #32 ext_clock_pin = ~ext_clock_pin;
    // released transmit pin is pulled high
    assign txLine = serialOutPinOe ? serialOutPin : 1'b1;
    uart_core #(.BAUD_DIV_RESET(12'h000)) u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serialInPin(serialInPin), .serialOutPin(serialOutPin),
        .serialOutPinOe(serialOutPinOe), .extClockPinIn(ext_clock_pin), .extClockPinOut(extClockPinOut),
        .extClockPinOe(extClockPinOe), .rxIrq(rxIrq), .txIrq(txIrq));
    line_partner u_line (.mclk(mclk), .lineIn(txLine), .lineOut(serialInPin));
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] q);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        apb(0, CTRL_IDX, 0, rd);
        chk("ctrl reset", 32'h01, rd);
        chk("mapped err", 0, slvErr);
        apb(0, INTCLK_IDX, 0, rd);
        chk("intclk reset", 32'h00, rd);
        apb(0, 10'h0c0, 0, rd);
        chk("unmapped", 32'h0, rd);
        chk("unmapped err", 1, slvErr);
        apb(1, INTCLK_IDX, 32'h23, rd);
        @(posedge mclk);
        chk("tx pin oe", 1, serialOutPinOe);
        chk("tx irq", 1, txIrq);
        for (int i = 0; i < 3; i++) begin
            apb(1, CTRL_IDX, (i == 0) ? 32'h00 : (i == 1) ? 32'ha8 : 32'hc8, rd);
            fork
                u_line.recv(bits);
                apb(1, TXBUF_IDX, (i == 0) ? 32'ha5 : 32'h55, rd);
            join
            chk("tx frame", (i == 0) ? 10'h34a : {1'b1, i == 2, 7'h55, 1'b0}, bits);
            repeat (16) @(posedge mclk);
            apb(0, RXSTAT_IDX, 0, rd);
            chk("transmitting", 0, rd[1]);
        end
        apb(1, CTRL_IDX, 32'h00, rd);
        u_line.send({1'b1, 8'h3c, 1'b0});
        u_line.send({1'b1, 8'h77, 1'b0});
        u_line.send({1'b0, 8'h11, 1'b0});
        repeat (32) @(posedge mclk);
        chk("rx irq", 1, rxIrq);
        apb(0, CTRL_IDX, 0, rd);
        chk("full and error", 32'h06, rd & 32'h06);
        apb(0, RXSTAT_IDX, 0, rd);
        chk("overrun framing", 32'hc0, rd & 32'hc0);
        apb(0, RXSTAT_IDX, 0, rd);
        chk("errors cleared", 32'h00, rd & 32'he0);
        apb(0, RXBUF_IDX, 0, rd);
        chk("rx data kept", 32'h3c, rd);
        apb(0, CTRL_IDX, 0, rd);
        chk("full cleared", 32'h00, rd & 32'h06);
        apb(1, INTCLK_IDX, 32'he3, rd);
        apb(1, CTRL_IDX, 32'h38, rd);
        apb(1, RXSTAT_IDX, 32'h04, rd);
        apb(1, TXBUF_IDX, 32'h5a, rd);
        repeat (180) @(posedge mclk);
        apb(0, RXSTAT_IDX, 0, rd);
        chk("ninth attention_mode busy", 32'h0a, rd);
        repeat (6) @(posedge mclk);
        apb(0, RXSTAT_IDX, 0, rd);
        chk("short stop end", 32'h08, rd);
        apb(0, RXBUF_IDX, 0, rd);
        chk("loop data", 32'h5a, rd);
        apb(1, INTCLK_IDX, 32'h2f, rd);
        apb(1, TXBUF_IDX, 32'hc3, rd);
        repeat (1000) @(posedge mclk);
        apb(0, CTRL_IDX, 0, rd);
        chk("ext clk pace", 32'h00, rd & 32'h02);
        repeat (2000) @(posedge mclk);
        apb(0, RXBUF_IDX, 0, rd);
        chk("ext clk data", 32'hc3, rd);
        apb(1, INTCLK_IDX, 32'h33, rd);
        apb(1, TXBUF_IDX, 32'h96, rd);
        repeat (40) @(posedge mclk);
        apb(0, RXBUF_IDX, 0, rd);
        chk("sync data", 32'h96, rd);
        apb(1, BAUD_IDX, 32'h10000, rd);
        @(posedge mclk);
        chk("ckx oe", 1, extClockPinOe);
        bits[0] = extClockPinOut;
        @(posedge mclk);
        chk("ckx clock", !bits[0], extClockPinOut);
        wrap_up();
    end
endmodule
